/* core/dio_deglitch.sv */
// matched deglitch filter: the level follows the input only after it held steady
`timescale 1ns/10ps
module dio_deglitch #(
    parameter int STABLE_CYC = 4
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic raw_i,
    output logic level_o,
    output logic rise_o
);
    import dio_pkg::*;

    localparam int CNT_W = $clog2(STABLE_CYC + 1);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STABLE_CYC);

    logic [CNT_W-1:0] run_r;

    initial begin
        if (STABLE_CYC < 1) begin
            $error("dio_deglitch: STABLE_CYC must be at least 1");
        end
    end

    // ****************************************
    // run counter
    // ****************************************
    // counts cycles the input has differed from the accepted level
    always_ff @(posedge core_clk_i) begin
        if (srst_i || raw_i == level_o || run_r == CNT_LAST) begin
            run_r <= '0;
        end else begin
            run_r <= run_r + CNT_ONE;
        end
    end

    // a change shorter than the window never reaches the level
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            level_o <= 1'b0;
            rise_o <= 1'b0;
        end else begin
            rise_o <= 1'b0;
            if (raw_i != level_o && run_r == CNT_LAST - CNT_ONE) begin
                level_o <= raw_i; // [R5]
                rise_o <= raw_i;
            end
        end
    end
endmodule

/* core/dio_pkg.sv */
// package: offsets, field layout, reset values and timing for the digital i/o and dac block
package dio_pkg;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [3:0] DIO_OFS_DIGITAL_PORT = 4'h3;
    localparam logic [3:0] DIO_OFS_DAC_A_LOW = 4'h4;
    localparam logic [3:0] DIO_OFS_DAC_A_HIGH = 4'h5;
    // ****************************************
    // field layout
    // ****************************************
    localparam int DIO_NIBBLE_W = 4;
    localparam int DIO_BYTE_W = 8;
    localparam int DIO_WORD_W = 16;
    localparam int DIO_LEGACY_W = 12;
    localparam int DIO_PAD_W = DIO_WORD_W - DIO_LEGACY_W;
    localparam int DIO_IN_EXT_TRIGGER_IN_BIT = 0;
    localparam int DIO_IN_GATE_BIT = 2;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [3:0] DIO_DOUT_RST = 4'h0;
    localparam logic [7:0] DIO_LOW_RST = 8'h00;
    localparam logic [15:0] DIO_DAC_ZERO_UNIPOLAR = 16'h0000;
    localparam logic [15:0] DIO_DAC_ZERO_BIPOLAR = 16'h8000;
    localparam logic [1:0] DIO_PAD_ZERO = 2'h0;
    localparam logic [15:0] DIO_RDATA_IDLE = 16'h0000;
    // ****************************************
    // timing
    // ****************************************
    localparam int DIO_CLK_PERIOD_PS = 50000;
    localparam int DIO_EXT_TRIGGER_IN_MIN_PULSE_PS = 200000;
    localparam int DIO_EXT_TRIGGER_IN_MIN_CYC =
        (DIO_EXT_TRIGGER_IN_MIN_PULSE_PS + DIO_CLK_PERIOD_PS - 1) / DIO_CLK_PERIOD_PS;
endpackage

/* core/dio_regs.sv */
// digital output/input port and dac channel a register logic
//
// Function
// [R1] write offset 0x3: bits 3:0 drive outputs, upper bits ignored, reset 0000, no readback
// [R2] host software keeps its own shadow of the output nibble
// [R3] read offset 0x3: input pins in bits 3:0, compatibility mode in 7:6
// [R4] input bit 0 also feeds the adc external trigger
// [R5] trigger path deglitched, only pulses of at least 200 ns accepted
// [R6] input bit 2 also drives counter zero gate
// [R7] dac code is 16 bits, low byte offset 0x4, high byte 0x5
// [R8] dac output changes only on a high-byte write; low byte is held
// [R9] high-byte-only write updates using the last held low byte
// [R10] range jumper changes reach the dac only at the next high-byte write
// [R11] word write at 0x4 loads both bytes and updates at once
// [R12] reset puts the dac output at zero volts
// [R13] dac always enabled and writable in both compatibility modes
// [R14] dac data alignment selectable: 12-bit legacy or full 16-bit
// [R15] 16-bit code is straight binary, zero is low end of range
// [R16] full 16-bit word transferred to converter in one step
`timescale 1ns/10ps
module dio_regs #(
    parameter int EXT_TRIGGER_IN_MIN_CYC = dio_pkg::DIO_EXT_TRIGGER_IN_MIN_CYC
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic [3:0] io_addr_i,
    input wire logic [15:0] io_wdata_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic io_word_i,
    output logic [15:0] io_rdata_o,
    output logic io_rvalid_o,
    input wire logic [3:0] din_pins_i,
    input wire logic compat_mode_i,
    input wire logic dac_a_range_polarity_jumper_i,
    input wire logic dac_a_range_span_jumper_i,
    input wire logic dac_align_16_i,
    output logic [3:0] dout_pins_o,
    output logic ext_trigger_in_o,
    output logic ext_trigger_pulse_o,
    output logic counter_zero_gate_o,
    output logic [15:0] dac_a_code_o,
    output logic dac_a_load_o,
    output logic dac_a_range_polarity_o,
    output logic dac_a_range_span_o
);
    import dio_pkg::*;

    initial begin
        if (EXT_TRIGGER_IN_MIN_CYC < 1) begin
            $error("dio_regs: EXT_TRIGGER_IN_MIN_CYC must be at least 1");
        end
    end

    // ****************************************
    // pin synchronisers
    // ****************************************
    // not reset: pure data path, settles within two cycles of any reset
    logic [7:0] pin_meta_r;
    logic [7:0] pin_sync_r;
    logic [3:0] din_sync;
    logic compat_sync;
    logic pol_sync;
    logic span_sync;
    logic align_sync;

    always_ff @(posedge core_clk_i) begin
        pin_meta_r <= {din_pins_i, compat_mode_i, dac_a_range_polarity_jumper_i,
                       dac_a_range_span_jumper_i, dac_align_16_i};
        pin_sync_r <= pin_meta_r;
    end

    assign din_sync = pin_sync_r[7:4];
    assign compat_sync = pin_sync_r[3];
    assign pol_sync = pin_sync_r[2];
    assign span_sync = pin_sync_r[1];
    assign align_sync = pin_sync_r[0];

    // ****************************************
    // access decode
    // ****************************************
    logic wr_port;
    logic wr_low;
    logic wr_high;
    logic rd_port;
    logic [7:0] low_in;
    logic [7:0] high_in;
    logic word_low;

    assign wr_port = io_wr_i && !io_word_i && io_addr_i == DIO_OFS_DIGITAL_PORT;
    // only a word cycle at the low offset brings both bytes
    assign word_low = io_word_i && io_addr_i == DIO_OFS_DAC_A_LOW; // [R11]
    // byte cycles carry their data on bits 7:0, word cycles on 15:0
    assign wr_low = io_wr_i && io_addr_i == DIO_OFS_DAC_A_LOW; // [R7]
    assign wr_high = io_wr_i && (io_addr_i == DIO_OFS_DAC_A_HIGH || word_low); // [R11]
    assign rd_port = io_rd_i && io_addr_i == DIO_OFS_DIGITAL_PORT;
    assign low_in = io_wdata_i[DIO_BYTE_W-1:0];
    assign high_in = io_word_i ? io_wdata_i[DIO_WORD_W-1:DIO_BYTE_W] : io_wdata_i[DIO_BYTE_W-1:0];

    // ****************************************
    // digital output port
    // ****************************************
    // write only; host keeps the shadow copy for bit manipulation
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            dout_pins_o <= DIO_DOUT_RST; // [R1]
        end else if (wr_port) begin
            dout_pins_o <= io_wdata_i[DIO_NIBBLE_W-1:0]; // [R1] [R2]
        end
    end

    // ****************************************
    // digital input port read
    // ****************************************
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            io_rdata_o <= DIO_RDATA_IDLE;
            io_rvalid_o <= 1'b0;
        end else begin
            io_rvalid_o <= io_rd_i;
            // unmapped and write-only offsets read as zero
            if (rd_port) begin
                io_rdata_o <= {DIO_BYTE_W'(0), {2{compat_sync}}, DIO_PAD_ZERO, din_sync}; // [R3]
            end else begin
                io_rdata_o <= DIO_RDATA_IDLE;
            end
        end
    end

    // ****************************************
    // shared input functions
    // ****************************************
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            counter_zero_gate_o <= 1'b0;
        end else begin
            counter_zero_gate_o <= din_sync[DIO_IN_GATE_BIT]; // [R6]
        end
    end

    dio_deglitch #(
        .STABLE_CYC(EXT_TRIGGER_IN_MIN_CYC)
    ) u_ext_trigger_in_filter (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .raw_i(din_sync[DIO_IN_EXT_TRIGGER_IN_BIT]), // [R4]
        .level_o(ext_trigger_in_o),
        .rise_o(ext_trigger_pulse_o)
    );

    // ****************************************
    // dac channel a
    // ****************************************
    logic [7:0] low_hold_r;
    logic [15:0] word_nxt;
    logic [15:0] code_nxt;

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            low_hold_r <= DIO_LOW_RST;
        end else if (wr_low) begin
            low_hold_r <= low_in; // [R8]
        end
    end

    // a word write at the low offset brings its own low byte, any other write reuses the held one
    assign word_nxt = {high_in, (word_low ? low_in : low_hold_r)}; // [R9] [R11]
    // legacy: 12-bit right justified code moved into the top of the converter word
    assign code_nxt = align_sync ? word_nxt :
                      {word_nxt[DIO_LEGACY_W-1:0], DIO_PAD_W'(0)}; // [R14] [R15]

    // no enable gating: writable whatever the compatibility mode
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            dac_a_code_o <= pol_sync ? DIO_DAC_ZERO_BIPOLAR : DIO_DAC_ZERO_UNIPOLAR; // [R12]
            dac_a_range_polarity_o <= pol_sync;
            dac_a_range_span_o <= span_sync;
            dac_a_load_o <= 1'b0;
        end else begin
            dac_a_load_o <= wr_high;
            if (wr_high) begin
                dac_a_code_o <= code_nxt; // [R8] [R13] [R16]
                dac_a_range_polarity_o <= pol_sync; // [R10]
                dac_a_range_span_o <= span_sync; // [R10]
            end
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (srst_i);

    sequence s_high_write;
        wr_high;
    endsequence

    sequence s_low_only;
        wr_low && !wr_high;
    endsequence

    a_dout_write_value: assert property (wr_port |=> dout_pins_o == $past(io_wdata_i[3:0])) // [R1]
        else $error("output port did not take written nibble");
    a_dout_hold_value: assert property (!wr_port |=> $stable(dout_pins_o)) // [R1]
        else $error("output port changed without a write");
    a_port_read_data: assert property (rd_port |=> io_rvalid_o && // [R3]
        io_rdata_o == {8'h00, {2{$past(compat_sync)}}, 2'h0, $past(din_sync)})
        else $error("input port read returned wrong data");
    a_gate_follows_pin: assert property (##1 counter_zero_gate_o == $past(din_sync[2])) // [R6]
        else $error("counter gate does not follow input bit two");
    // a filter that passed the input straight through would show the pulse here
    a_ext_trigger_in_short_reject: assert property ((!ext_trigger_in_o && !din_sync[0]) ##1 // [R5]
        din_sync[0] [*2] ##1 !din_sync[0] |-> !ext_trigger_in_o [*3])
        else $error("short pulse reached the trigger");
    a_ext_trigger_in_long_accept: assert property ((!ext_trigger_in_o && !din_sync[0]) ##1 // [R5]
        din_sync[0] [*4] |=> ext_trigger_in_o && ext_trigger_pulse_o)
        else $error("long pulse did not trigger");
    a_dac_low_hold: assert property (s_low_only |=> $stable(dac_a_code_o)) // [R8]
        else $error("dac changed on low byte write");
    a_dac_high_update: assert property (s_high_write ##0 (align_sync && !io_word_i) |=> // [R9]
        dac_a_code_o == {$past(io_wdata_i[7:0]), $past(low_hold_r)} && dac_a_load_o)
        else $error("high byte write did not load held low byte");
    a_dac_word_update: assert property (s_high_write ##0 (align_sync && word_low) |=> // [R11]
        dac_a_code_o == $past(io_wdata_i))
        else $error("word write did not load both bytes");
    a_dac_legacy_align: assert property (s_high_write ##0 (!align_sync && word_low) |=> // [R14]
        dac_a_code_o == {$past(io_wdata_i[11:0]), 4'h0})
        else $error("legacy alignment wrong");
    a_range_latch: assert property (!wr_high |=> $stable(dac_a_range_polarity_o) && // [R10]
        $stable(dac_a_range_span_o))
        else $error("range changed without high byte write");
    // unreset synchronisers need a few reset edges before the polarity is known
    a_dac_reset_zero: assert property (@(posedge core_clk_i) disable iff (1'b0) // [R12]
        srst_i [*3] |=> dac_a_code_o == ($past(pol_sync) ? 16'h8000 : 16'h0000))
        else $error("dac not at zero volts after reset");
endmodule

/* dv/dio_host_model.sv */
// host cpu model issuing byte and word i/o cycles
`timescale 1ns/10ps
module dio_host_model (
    input wire logic core_clk_i,
    input wire logic [15:0] io_rdata_i,
    input wire logic io_rvalid_i,
    output logic [3:0] io_addr_o,
    output logic [15:0] io_wdata_o,
    output logic io_wr_o,
    output logic io_rd_o,
    output logic io_word_o
);
    import dio_pkg::*;
    logic [3:0] dout_shadow_r = 4'h0;
    initial begin
        io_addr_o = 4'h0;
        io_wdata_o = 16'h0000;
        io_wr_o = 1'b0;
        io_rd_o = 1'b0;
        io_word_o = 1'b0;
    end
    task automatic bus_write(input logic [3:0] addr, input logic [15:0] data, input logic word);
        @(posedge core_clk_i);
        io_addr_o <= addr;
        io_wdata_o <= data;
        io_word_o <= word;
        io_wr_o <= 1'b1;
        @(posedge core_clk_i);
        io_wr_o <= 1'b0;
        // released data shows the inverse, never the last value
        io_wdata_o <= ~data;
        #1;
    endtask
    task automatic bus_read(input logic [3:0] addr, output logic [15:0] data, output logic valid);
        @(posedge core_clk_i);
        io_addr_o <= addr;
        io_word_o <= 1'b0;
        io_rd_o <= 1'b1;
        @(posedge core_clk_i);
        io_rd_o <= 1'b0;
        #1;
        data = io_rdata_i;
        valid = io_rvalid_i;
    endtask
    // port cannot be read back, so single bits go through a shadow
    task automatic set_out_bit(input int idx, input logic val);
        dout_shadow_r[idx] = val;
        bus_write(DIO_OFS_DIGITAL_PORT, {8'h00, 4'hF, dout_shadow_r}, 1'b0);
    endtask
endmodule

/* dv/testbench.sv */
// self-checking bench for the digital i/o and dac register block
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin err_total++; \
    $display("unexpected %s exp %h got %h", nm, exp, got); end end
module testbench;
    import dio_pkg::*;
    logic clk, srst, wr, rd, word, rvalid, cm, pol, span, al16, vld;
    logic gate, ext_trigger_in_lvl, ext_trigger_in_pulse, load, rng_pol, rng_span;
    logic [3:0] addr, din, dout;
    logic [15:0] wdata, rdata, dac, rdv, prev, lfsr, w;
    int err_total = 0;
    int checked = 0;
    int pulses = 0;
    int p0;
    int cyc = 0;
    dio_regs #(.EXT_TRIGGER_IN_MIN_CYC(4)) DUT (.core_clk_i(clk), .srst_i(srst), .io_addr_i(addr), .io_wdata_i(wdata),
        .io_wr_i(wr), .io_rd_i(rd), .io_word_i(word), .io_rdata_o(rdata), .io_rvalid_o(rvalid),
        .din_pins_i(din), .compat_mode_i(cm), .dac_a_range_polarity_jumper_i(pol),
        .dac_a_range_span_jumper_i(span), .dac_align_16_i(al16), .dout_pins_o(dout),
        .ext_trigger_in_o(ext_trigger_in_lvl), .ext_trigger_pulse_o(ext_trigger_in_pulse), .counter_zero_gate_o(gate),
        .dac_a_code_o(dac), .dac_a_load_o(load), .dac_a_range_polarity_o(rng_pol), .dac_a_range_span_o(rng_span));
    dio_host_model host (.core_clk_i(clk), .io_rdata_i(rdata), .io_rvalid_i(rvalid), .io_addr_o(addr),
        .io_wdata_o(wdata), .io_wr_o(wr), .io_rd_o(rd), .io_word_o(word));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // legacy alignment moves the right-justified 12 bits to the top
    function automatic logic [15:0] dac_exp(input logic [7:0] hi, input logic [7:0] lo, input logic a16);
        dac_exp = a16 ? {hi, lo} : {hi[3:0], lo, 4'h0};
    endfunction
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic do_reset();
        srst <= 1'b1;
        wait_cyc(12);
        srst <= 1'b0;
        #1;
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        if (ext_trigger_in_pulse === 1'b1) begin
            pulses <= pulses + 1;
        end
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            end_of_test();
        end
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        srst = 1'b1;
        din = 4'h0;
        cm = 1'b0;
        pol = 1'b0;
        span = 1'b0;
        al16 = 1'b1;
        lfsr = 16'h002D;
        do_reset();
        `CHK("dout_rst", 4'h0, dout)
        `CHK("dac_rst", 16'h0000, dac)
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            host.set_out_bit(i, 1'b1);
            `CHK("dout_bit", host.dout_shadow_r, dout)
        end
        lfsr = lfsr_next(lfsr);
        host.bus_write(DIO_OFS_DIGITAL_PORT, lfsr, 1'b0);
        `CHK("dout_rnd", lfsr[3:0], dout)
        host.bus_write(DIO_OFS_DIGITAL_PORT, ~lfsr, 1'b1);
        host.bus_write(4'h6, ~lfsr, 1'b0);
        `CHK("dout_keep", lfsr[3:0], dout)
        $display("test output port done");
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            @(posedge clk);
            din <= lfsr[3:0];
            cm <= i[0];
            wait_cyc(5);
            host.bus_read(DIO_OFS_DIGITAL_PORT, rdv, vld);
            `CHK("rd_valid", 1'b1, vld)
            `CHK("rd_data", {8'h00, cm, cm, 2'b00, din}, rdv)
            `CHK("gate", din[2], gate)
        end
        host.bus_read(DIO_OFS_DAC_A_LOW, rdv, vld);
        `CHK("rd_other", 16'h0000, rdv)
        `CHK("rd_other_vld", 1'b1, vld)
        $display("test input port done");
        for (int i = 0; i < 8; i++) begin
            lfsr = lfsr_next(lfsr);
            @(posedge clk);
            al16 <= lfsr[0];
            cm <= lfsr[1];
            wait_cyc(4);
            prev = dac;
            host.bus_write(DIO_OFS_DAC_A_LOW, {8'h00, lfsr[15:8]}, 1'b0);
            `CHK("dac_hold", prev, dac)
            `CHK("load_low", 1'b0, load)
            host.bus_write(DIO_OFS_DAC_A_HIGH, {8'h00, lfsr[7:0]}, 1'b0);
            `CHK("dac_pair", dac_exp(lfsr[7:0], lfsr[15:8], al16), dac)
            `CHK("load_high", 1'b1, load)
            host.bus_write(DIO_OFS_DAC_A_HIGH, {8'h00, ~lfsr[7:0]}, 1'b0);
            `CHK("dac_hi_only", dac_exp(~lfsr[7:0], lfsr[15:8], al16), dac)
            w = lfsr ^ 16'h5A3C;
            host.bus_write(DIO_OFS_DAC_A_LOW, w, 1'b1);
            `CHK("dac_word", dac_exp(w[15:8], w[7:0], al16), dac)
        end
        $display("test dac data done");
        @(posedge clk);
        pol <= 1'b1;
        span <= 1'b1;
        wait_cyc(4);
        `CHK("range_wait", 1'b0, rng_pol)
        `CHK("range_wait_span", 1'b0, rng_span)
        host.bus_write(DIO_OFS_DAC_A_HIGH, 16'h00AB, 1'b0);
        `CHK("range_pol", 1'b1, rng_pol)
        `CHK("range_span", 1'b1, rng_span)
        `CHK("range_dac", dac_exp(8'hAB, w[7:0], al16), dac)
        @(posedge clk);
        do_reset();
        `CHK("dac_rst_bip", 16'h8000, dac)
        $display("test range and reset done");
        @(posedge clk);
        din <= 4'h0;
        wait_cyc(8);
        p0 = pulses;
        din <= 4'h1;
        wait_cyc(2);
        din <= 4'h0;
        wait_cyc(10);
        `CHK("ext_trigger_in_short", 1'b0, ext_trigger_in_lvl)
        `CHK("pulse_short", p0, pulses)
        din <= 4'h1;
        wait_cyc(10);
        `CHK("ext_trigger_in_long", 1'b1, ext_trigger_in_lvl)
        `CHK("pulse_long", p0 + 1, pulses)
        din <= 4'h0;
        wait_cyc(10);
        `CHK("ext_trigger_in_fall", 1'b0, ext_trigger_in_lvl)
        $display("test trigger done");
        end_of_test();
    end
endmodule
